// ===== rtl/clk_switch_pkg.sv
// Constants, field layout and carrier types for the CPU clock switch control block
package clk_switch_pkg;
    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int CLK_FREQ_MHZ = 50;
    localparam int MAIN_MIN_INSTR_NS = 400;
    localparam int MAIN_MIN_INSTR_CYC = (MAIN_MIN_INSTR_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int SUB_INSTR_NS = 122000;
    localparam int SUB_INSTR_CYC = (SUB_INSTR_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int STAB_TIME_NS = 26214400;
    localparam int STAB_CYC = (STAB_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int TMR_W = 21;

    // ***************************************************************
    // Register map and fields
    // ***************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam int DIV_LSB = 0;
    localparam int SRC_REQ_BIT = 4;
    localparam int SRC_STATE_BIT = 5;
    localparam int FB_OFF_BIT = 6;
    localparam int OSC_STOP_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h04;
    localparam logic [2:0] DIV_SLOWEST = 3'h4;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_OSC_BIT = 1;
    localparam int ST_PEND_BIT = 2;

    // ***************************************************************
    // Carriers
    // ***************************************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } wb_rsp_t;

    typedef struct packed {
        logic run;
        logic sub_sel;
        logic [2:0] div;
        logic instr_tick;
        logic main_osc_en;
        logic feedback_off;
    } cpu_clk_t;
endpackage

// ===== rtl/cpu_clock_switch_control.sv
// CPU clock source and divider switch control with Wishbone register access
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module cpu_clock_switch_control
    import clk_switch_pkg::*;
#(
    parameter int SUB_INSTR_CYCLES = SUB_INSTR_CYC,
    parameter int STAB_CYCLES = STAB_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wb_req_t wb_req_i,
    output wb_rsp_t wb_rsp_o,
    output cpu_clk_t cpu_clk_o
);
    // ***************************************************************
    // Declarations
    // ***************************************************************
    typedef enum logic [1:0] {ST_START, ST_STAB, ST_RUN} phase_t;
    phase_t state;
    logic [2:0] cpu_divide_select;
    logic clock_source_request;
    logic main_osc_stop;
    logic feedback_off;
    logic active_sub;
    logic [2:0] active_div;
    logic [2:0] req_div;
    logic next_sub;
    logic [2:0] next_div;
    logic [TMR_W-1:0] instr_len;
    logic instr_expire;
    logic stab_expire;
    logic boundary;
    logic pending;
    logic bus_req;
    logic ctrl_write;
    // Longest main instruction, at the slowest division; bounds every wait on the main clock
    localparam int MAIN_MAX_GAP = MAIN_MIN_INSTR_CYC << int'(DIV_SLOWEST);
    logic ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    // ***************************************************************
    // Start-up sequence
    // ***************************************************************
    // Reset lands in ST_START with the oscillator off; the wait counts from release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_START;
        end else begin
            unique case (state)
                ST_START: begin
                    state <= ST_STAB;
                end
                ST_STAB: begin
                    if (stab_expire) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                // The spare code restarts the wait rather than running unclocked
                default: begin
                    state <= ST_START;
                end
            endcase
        end
    end

    interval_timer #(.W(TMR_W)) u_stab_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(state == ST_START),
        .load_value_i(TMR_W'(STAB_CYCLES)),
        .expire_o(stab_expire)
    );

    // ***************************************************************
    // Instruction timing and switch point
    // ***************************************************************
    // Prohibited divider codes run at the slowest rate rather than an undefined one
    assign req_div = (cpu_divide_select > DIV_SLOWEST) ? DIV_SLOWEST : cpu_divide_select;
    assign boundary = (state == ST_RUN) && instr_expire;
    assign pending = (clock_source_request != active_sub) || (!clock_source_request && req_div != active_div);

    // Changes apply only at the end of an old-clock instruction, which bounds every switch to one
    always_comb begin
        next_sub = boundary ? clock_source_request : active_sub;
        next_div = (boundary && !clock_source_request) ? req_div : active_div;
        if (next_sub) begin
            instr_len = TMR_W'(SUB_INSTR_CYCLES);
        end else begin
            instr_len = TMR_W'(MAIN_MIN_INSTR_CYC) << next_div;
        end
    end

    interval_timer #(.W(TMR_W)) u_instr_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i((state != ST_RUN) || instr_expire),
        .load_value_i(instr_len),
        .expire_o(instr_expire)
    );

    // Multiplexer select and status bit are one flop, so they never disagree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_sub <= 1'b0;
            active_div <= DIV_SLOWEST;
        end else begin
            active_sub <= next_sub;
            active_div <= next_div;
        end
    end

    // ***************************************************************
    // Wishbone slave
    // ***************************************************************
    assign bus_req = wb_req_i.cyc && wb_req_i.stb && !ack;
    assign ctrl_write = bus_req && wb_req_i.we && wb_req_i.sel[0] && (wb_req_i.adr == CTRL_OFFSET);

    // Control bits; only the low byte lane holds them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_divide_select <= CTRL_RESET[DIV_LSB +: 3];
            clock_source_request <= CTRL_RESET[SRC_REQ_BIT];
            feedback_off <= CTRL_RESET[FB_OFF_BIT];
            main_osc_stop <= CTRL_RESET[OSC_STOP_BIT];
        end else if (ctrl_write) begin
            cpu_divide_select <= wb_req_i.dat[DIV_LSB +: 3];
            clock_source_request <= wb_req_i.dat[SRC_REQ_BIT];
            feedback_off <= wb_req_i.dat[FB_OFF_BIT];
            main_osc_stop <= wb_req_i.dat[OSC_STOP_BIT];
        end
    end

    // Read mux; unmapped addresses answer with zero
    always_comb begin
        next_rdata = 32'h0;
        if (wb_req_i.adr == CTRL_OFFSET) begin
            next_rdata[DIV_LSB +: 3] = cpu_divide_select;
            next_rdata[SRC_REQ_BIT] = clock_source_request;
            next_rdata[SRC_STATE_BIT] = active_sub;
            next_rdata[FB_OFF_BIT] = feedback_off;
            next_rdata[OSC_STOP_BIT] = main_osc_stop;
        end else if (wb_req_i.adr == STATUS_OFFSET) begin
            next_rdata[ST_RUN_BIT] = (state == ST_RUN);
            next_rdata[ST_OSC_BIT] = cpu_clk_o.main_osc_en;
            next_rdata[ST_PEND_BIT] = pending;
        end
    end

    // One-cycle ack one edge after the strobe; dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ack <= bus_req;
            if (bus_req) begin
                rdata <= next_rdata;
            end
        end
    end

    assign wb_rsp_o.ack = ack;
    assign wb_rsp_o.dat = rdata;

    // ***************************************************************
    // Clock outputs
    // ***************************************************************
    // No hardware wait on restart: software owns stability before going back to main
    assign cpu_clk_o.main_osc_en = (state != ST_START) && !(main_osc_stop && active_sub);
    assign cpu_clk_o.run = (state == ST_RUN);
    assign cpu_clk_o.sub_sel = active_sub;
    assign cpu_clk_o.div = active_div;
    assign cpu_clk_o.instr_tick = boundary;
    assign cpu_clk_o.feedback_off = feedback_off;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    a_reset_value: assert property (@(posedge clk_i) rst_i |=>
        (cpu_divide_select == DIV_SLOWEST) && !clock_source_request && !main_osc_stop && !active_sub)
        else $error("control register reset value wrong");
    a_switch_boundary: assert property (@(posedge clk_i) disable iff (rst_i)
        (active_sub != $past(active_sub)) || (active_div != $past(active_div)) |-> $past(boundary))
        else $error("clock changed outside an instruction boundary");
    a_write_deferred: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_write && !boundary |=> $stable(active_div) && $stable(active_sub))
        else $error("clock selection applied on the write itself");
    a_main_div_apply: assert property (@(posedge clk_i) disable iff (rst_i)
        boundary && !clock_source_request |=> !active_sub && (active_div == $past(req_div)))
        else $error("requested main division not applied at boundary");
    a_sub_apply: assert property (@(posedge clk_i) disable iff (rst_i)
        boundary && clock_source_request |=> active_sub)
        else $error("subsystem request not applied at boundary");
    a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !wb_req_i.we && (wb_req_i.adr == CTRL_OFFSET) |=> ack && (rdata[SRC_STATE_BIT] == $past(active_sub)))
        else $error("source status read mismatch");
    a_osc_reset_off: assert property (@(posedge clk_i) rst_i |=> !cpu_clk_o.main_osc_en)
        else $error("main oscillator enabled during reset");
    a_osc_stop_sub: assert property (@(posedge clk_i) disable iff (rst_i)
        (state != ST_START) && !cpu_clk_o.main_osc_en |-> active_sub && main_osc_stop)
        else $error("main oscillator stopped while on main clock");
    a_osc_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        (state != ST_START) && !main_osc_stop |-> cpu_clk_o.main_osc_en)
        else $error("main oscillator not restarted");
    a_start_slow: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(cpu_clk_o.run) |-> $past(stab_expire) && (active_div == DIV_SLOWEST) && !active_sub)
        else $error("execution did not start slow after stabilisation");
    a_stab_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_START |=> !cpu_clk_o.run [*2])
        else $error("execution started without stabilisation wait");
    a_main_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == ST_RUN) && !active_sub |-> ##[0:MAIN_MAX_GAP] boundary)
        else $error("no instruction boundary within the slowest main instruction");
    a_pending_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        boundary && !ctrl_write |=> !pending)
        else $error("switch still pending after boundary");

    c_to_sub: cover property (@(posedge clk_i) disable iff (rst_i) $rose(active_sub));
    c_to_main: cover property (@(posedge clk_i) disable iff (rst_i) $fell(active_sub));
    c_div_change: cover property (@(posedge clk_i) disable iff (rst_i) !active_sub && $changed(active_div));
    c_osc_stop: cover property (@(posedge clk_i) disable iff (rst_i) $fell(cpu_clk_o.main_osc_en));
    c_return_div: cover property (@(posedge clk_i) disable iff (rst_i) $fell(active_sub) && $changed(active_div));
endmodule

// ===== rtl/interval_timer.sv
// Reloadable down counter that marks the end of a programmed interval
`timescale 1ns/100ps
module interval_timer #(
    parameter int W = 21
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_value_i,
    output logic expire_o
);
    logic [W-1:0] count;

    // A load of V makes expire_o rise V-1 cycles later, so a reload on expiry gives a period of V
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= load_value_i - 1'b1;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign expire_o = (count == '0);
endmodule

// ===== tb/cpu_core_model.sv
// Behavioural model of the CPU core that times instruction boundaries
`timescale 1ns/100ps
module cpu_core_model
    import clk_switch_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cpu_clk_t cpu_clk_i,
    output logic [15:0] gap_o
);
    logic [15:0] count;

    // Measure the span between two boundaries; a held core has no instructions to time
    always_ff @(posedge clk_i) begin
        if (rst_i || !cpu_clk_i.run) begin
            count <= 16'h0001;
            gap_o <= 16'h0000;
        end else if (cpu_clk_i.instr_tick) begin
            gap_o <= count;
            count <= 16'h0001;
        end else begin
            count <= count + 16'h0001;
        end
    end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the CPU clock switch control block
`timescale 1ns/100ps
module testbench
    import clk_switch_pkg::*;
;
    // Short counts keep the run brief; the sub-clock and stabilisation waits derive from them
    localparam int SUB_N = 50;
    localparam int STAB_N = 40;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    wb_req_t wb_req = '0;
    wb_rsp_t wb_rsp;
    cpu_clk_t cpu_clk;
    logic [15:0] gap;
    logic [31:0] rd;
    int mismatches = 0;
    int n_tests = 0;
    int n;

    always #10 clk_i = ~clk_i;

    cpu_clock_switch_control #(.SUB_INSTR_CYCLES(SUB_N), .STAB_CYCLES(STAB_N)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .cpu_clk_o(cpu_clk));
    cpu_core_model model_u (.clk_i(clk_i), .rst_i(rst_i), .cpu_clk_i(cpu_clk), .gap_o(gap));

    // ***************************************************************
    // Tasks
    // ***************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic single cycle; held until ack, then one idle cycle so the slave never re-takes it
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: {24'h000000, d}};
        do @(posedge clk_i); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk_i);
    endtask

    // Bounded wait for the mux to settle on a source and divider
    task automatic wait_sel(input logic s, input logic [2:0] d, input int lim);
        n = 0;
        while ((cpu_clk.sub_sel !== s || cpu_clk.div !== d) && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ***************************************************************
    // Sequence
    // ***************************************************************
    initial begin
        repeat (12) @(posedge clk_i);
        check("osc_en_in_reset", 32'h0, cpu_clk.main_osc_en);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, CTRL_OFFSET, 8'h00);
        check("ctrl_reset", 32'h04, rd);
        bus(1'b0, STATUS_OFFSET, 8'h00);
        check("status_in_wait", 32'h02, rd);
        n = 0;
        while (cpu_clk.run !== 1'b1 && n < STAB_N + 10) begin
            @(posedge clk_i);
            n++;
        end
        check("run", 32'h1, cpu_clk.run);
        check("start_clock", 32'h04, {cpu_clk.sub_sel, cpu_clk.div});
        $display("Test reset done");
        bus(1'b1, CTRL_OFFSET, 8'h00);
        check("div_held", 32'h4, cpu_clk.div);
        bus(1'b0, STATUS_OFFSET, 8'h00);
        check("status_pending", 32'h07, rd);
        wait_sel(1'b0, 3'h0, 322);
        check("div_fast", 32'h0, cpu_clk.div);
        repeat (45) @(posedge clk_i);
        check("main_gap", 32'h14, gap);
        $display("Test divider done");
        bus(1'b1, CTRL_OFFSET, 8'h80);
        repeat (60) @(posedge clk_i);
        check("osc_kept", 32'h1, {cpu_clk.sub_sel, cpu_clk.main_osc_en});
        bus(1'b1, CTRL_OFFSET, 8'h90);
        wait_sel(1'b1, 3'h0, 22);
        check("to_sub", 32'h1, cpu_clk.sub_sel);
        check("osc_stopped", 32'h0, cpu_clk.main_osc_en);
        bus(1'b0, CTRL_OFFSET, 8'h00);
        check("ctrl_on_sub", 32'hB0, rd);
        repeat (2 * SUB_N + 5) @(posedge clk_i);
        check("sub_gap", 32'h32, gap);
        $display("Test to subsystem done");
        bus(1'b1, CTRL_OFFSET, 8'h10);
        check("osc_restart", 32'h3, {cpu_clk.sub_sel, cpu_clk.main_osc_en});
        repeat (STAB_N) @(posedge clk_i);
        bus(1'b1, CTRL_OFFSET, 8'h02);
        wait_sel(1'b0, 3'h2, SUB_N + 2);
        check("back_to_main", 32'h02, {cpu_clk.sub_sel, cpu_clk.div});
        bus(1'b0, CTRL_OFFSET, 8'h00);
        check("ctrl_on_main", 32'h02, rd);
        $display("Test back to main done");
        bus(1'b1, 8'h20, 8'hFF);
        bus(1'b0, 8'h20, 8'h00);
        check("unmapped", 32'h0, rd);
        bus(1'b0, CTRL_OFFSET, 8'h00);
        check("ctrl_kept", 32'h02, rd);
        bus(1'b1, CTRL_OFFSET, 8'h42);
        check("fb_off", 32'h1, cpu_clk.feedback_off);
        bus(1'b0, CTRL_OFFSET, 8'h00);
        check("ctrl_fb", 32'h42, rd);
        $display("Test unmapped done");
        complete_run();
    end

    // Whole sequence needs under 2000 cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        complete_run();
    end
endmodule
